/* File: verilog/dwt_defs.svh */
// register offsets, key values, reset values and control fields of the dual watchdog
`ifndef DWT_DEFS_SVH
`define DWT_DEFS_SVH

// software watchdog register offsets
`define DWT_SW_LOAD 8'h00
`define DWT_SW_VALUE 8'h04
`define DWT_SW_KICK 8'h08
`define DWT_SW_CTL 8'h0C
`define DWT_SW_RIS 8'h10
`define DWT_SW_KEY 8'h14
`define DWT_SW_DIV 8'h18

// hardware watchdog register offsets
`define DWT_HW_LOAD 8'h40
`define DWT_HW_VALUE 8'h44
`define DWT_HW_KICK 8'h48
`define DWT_HW_CTL 8'h4C
`define DWT_HW_RIS 8'h50
`define DWT_HW_KEY 8'h54

// key values written to the access key registers
`define DWT_UNLOCK_KEY 32'h1ACCE551
`define DWT_CTL_KEY 32'hE5331AAE

// reset values
`define DWT_SW_LOAD_RST 32'hFFFFFFFF
`define DWT_HW_LOAD_RST 32'h0000FFFF
`define DWT_SW_CTL_RST 2'h0
`define DWT_HW_CTL_RST 2'h3
`define DWT_SW_DIV_RST 8'h00

// control register fields
`define DWT_CTL_IRQ_BIT 0
`define DWT_CTL_RST_BIT 1

`endif

/* File: verilog/dwt_pkg.sv */
// types shared by the dual watchdog modules
package dwt_pkg;

   // hardware watchdog access state
   typedef enum logic [1:0] {
      DWT_LOCKED,
      DWT_OPEN,
      DWT_CTL_OPEN
   } dwt_lock_t;

   // state of one watchdog counter
   typedef struct packed {
      logic [31:0] count;
      logic irq;
      logic rst_req;
      logic run;
   } dwt_core_st_t;

   // state of the register block
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [31:0] sw_load;
      logic [1:0] sw_ctl;
      logic sw_locked;
      logic [7:0] sw_div;
      logic [7:0] sw_div_cnt;
      logic sw_tick;
      logic sw_reload;
      logic [31:0] hw_load;
      logic [1:0] hw_ctl;
      dwt_lock_t hw_lock;
      logic hw_kick_half;
      logic [7:0] hw_kick_val;
      logic hw_reload;
      logic osc_s1;
      logic osc_s2;
      logic osc_s3;
      logic hw_tick;
   } dwt_top_st_t;

endpackage

/* File: verilog/dwt_core.sv */
// one watchdog down counter with underflow interrupt and reset request
`timescale 1ns/1ns
`default_nettype none

module dwt_core #(
   parameter logic [31:0] COUNT_RST = 32'h00000000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic enable,
   input wire logic rst_en,
   input wire logic reload,
   input wire logic [31:0] load_val,
   output logic [31:0] count,
   output logic irq,
   output logic rst_req
);

   dwt_pkg::dwt_core_st_t st;
   dwt_pkg::dwt_core_st_t next_st;
   logic start;
   logic under;

   // counting, reload, interrupt and reset decisions
   always_comb begin
      next_st = st;
      start = enable && !st.run;
      under = enable && st.run && tick && (st.count == 32'h00000000);
      next_st.run = enable;
      if (start || (enable && reload) || under) begin
         next_st.count = load_val;
      end else if (enable && tick) begin
         next_st.count = st.count - 32'h00000001;
      end
      if (enable && reload) begin
         next_st.irq = 1'b0;
      end
      if (under) begin
         next_st.irq = 1'b1;
         if (st.irq && rst_en) begin
            next_st.rst_req = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '{count: COUNT_RST, irq: 1'b0, rst_req: 1'b0, run: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign count = st.count;
   assign irq = st.irq;
   assign rst_req = st.rst_req;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_start_reload: assert property ($rose(enable) && !st.run |=> st.count == $past(load_val))
      else $error("counter not reloaded on start");
   a_stop_holds: assert property (!enable |=> $stable(st.count))
      else $error("counter moved while stopped");
   a_underflow_irq: assert property (under |=> st.irq && st.count == $past(load_val))
      else $error("underflow did not raise interrupt");
   a_second_reset: assert property (under && st.irq && rst_en |=> st.rst_req)
      else $error("second underflow gave no reset");
   a_first_no_rst: assert property (under && !st.irq |=> st.rst_req == $past(st.rst_req))
      else $error("reset on first underflow");
   a_kick_clears: assert property (enable && st.run && reload && !under
      |=> !st.irq && st.count == $past(load_val))
      else $error("reload did not clear status");
   a_count_dec: assert property (enable && st.run && tick && !reload && st.count != 32'h0
      |=> st.count == $past(st.count) - 32'h1)
      else $error("counter did not decrement");

   c_underflow: cover property (under);
   c_reset_req: cover property ($rose(st.rst_req));

endmodule

`default_nettype wire

/* File: verilog/dwt_top.sv */
// dual watchdog: apb registers, locks, prescaler, oscillator sync and two counters
`timescale 1ns/1ns
`default_nettype none
`include "dwt_defs.svh"

// Overview of operation
// - each value register reads the live down counter
// - underflow raises interrupt and reset as the control enables select
// - interrupt enable off stops; interrupt only; both: interrupt then reset
// - setting the interrupt enable starts the counter
// - software registers start unlocked; any non-key value locks them
// - any write to software kick reloads the counter while unlocked
// - software watchdog stays unlocked after a kick
// - software watchdog stops on interrupt enable zero or any reset
// - hardware load is 32 bits, counts oscillator ticks, resets to 0000FFFF
// - key write opens all hardware registers except control
// - control opens only after key then second key; wrong value restarts
// - hardware kick needs an 8-bit value then its inverse
// - hardware counter reloads on kick, zero, load write, restart
// - hardware value reads may be inexact; software reads twice
// - hardware registers relock after a kick
// - hardware watchdog stops on interrupt enable zero after double unlock
// - each status register shows a pending interrupt
// - software counter reloads on kick, zero, load write, restart
// - software load is 32 bits and resets to all ones
// - hardware counts low-speed oscillator; software counts divided bus clock
// - hardware watchdog runs from reset without software
module dwt_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic low_speed_osc_clock,
   output logic sw_irq,
   output logic sw_wdg_reset,
   output logic hw_irq,
   output logic hw_wdg_reset
);

   dwt_pkg::dwt_top_st_t st;
   dwt_pkg::dwt_top_st_t next_st;
   logic acc;
   logic wr;
   logic mapped;
   logic [31:0] rd;
   logic [31:0] sw_count;
   logic [31:0] hw_count;
   logic sw_pend;
   logic hw_pend;

   // read decode
   always_comb begin
      mapped = 1'b1;
      rd = 32'h00000000;
      case (paddr)
         `DWT_SW_LOAD: begin
            rd = st.sw_load;
         end
         `DWT_SW_VALUE: begin
            rd = sw_count;
         end
         `DWT_SW_KICK: begin
            rd = 32'h00000000;
         end
         `DWT_SW_CTL: begin
            rd = {30'h00000000, st.sw_ctl};
         end
         `DWT_SW_RIS: begin
            rd = {31'h00000000, sw_pend};
         end
         `DWT_SW_KEY: begin
            rd = {31'h00000000, st.sw_locked};
         end
         `DWT_SW_DIV: begin
            rd = {24'h000000, st.sw_div};
         end
         `DWT_HW_LOAD: begin
            rd = st.hw_load;
         end
         `DWT_HW_VALUE: begin
            rd = hw_count;
         end
         `DWT_HW_KICK: begin
            rd = 32'h00000000;
         end
         `DWT_HW_CTL: begin
            rd = {30'h00000000, st.hw_ctl};
         end
         `DWT_HW_RIS: begin
            rd = {31'h00000000, hw_pend};
         end
         `DWT_HW_KEY: begin
            rd = {31'h00000000, st.hw_lock == dwt_pkg::DWT_LOCKED};
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // bus handshake, prescaler, oscillator sync and register writes
   always_comb begin
      next_st = st;
      acc = psel && penable;
      wr = acc && st.pready && pwrite;
      next_st.pready = acc && !st.pready;
      next_st.pslverr = acc && !st.pready && !mapped;
      if (acc && !st.pready) begin
         next_st.prdata = pwrite ? 32'h00000000 : rd;
      end
      next_st.sw_reload = 1'b0;
      next_st.hw_reload = 1'b0;

      // software count tick from the divided bus clock
      if (st.sw_div_cnt == st.sw_div) begin
         next_st.sw_div_cnt = 8'h00;
         next_st.sw_tick = 1'b1;
      end else begin
         next_st.sw_div_cnt = st.sw_div_cnt + 8'h01;
         next_st.sw_tick = 1'b0;
      end

      // oscillator pin: two flops, then edge detect on the second
      next_st.osc_s1 = low_speed_osc_clock;
      next_st.osc_s2 = st.osc_s1;
      next_st.osc_s3 = st.osc_s2;
      next_st.hw_tick = st.osc_s2 && !st.osc_s3;

      if (wr) begin
         case (paddr)
            `DWT_SW_KEY: begin
               next_st.sw_locked = (pwdata != `DWT_UNLOCK_KEY);
            end
            `DWT_SW_LOAD: begin
               if (!st.sw_locked) begin
                  next_st.sw_load = pwdata;
                  next_st.sw_reload = 1'b1;
               end
            end
            `DWT_SW_KICK: begin
               if (!st.sw_locked) begin
                  next_st.sw_reload = 1'b1;
               end
            end
            `DWT_SW_CTL: begin
               if (!st.sw_locked) begin
                  next_st.sw_ctl = pwdata[1:0];
               end
            end
            `DWT_SW_DIV: begin
               if (!st.sw_locked) begin
                  next_st.sw_div = pwdata[7:0];
               end
            end
            `DWT_HW_KEY: begin
               next_st.hw_kick_half = 1'b0;
               if (pwdata == `DWT_UNLOCK_KEY) begin
                  next_st.hw_lock = dwt_pkg::DWT_OPEN;
               end else if (pwdata == `DWT_CTL_KEY && st.hw_lock == dwt_pkg::DWT_OPEN) begin
                  next_st.hw_lock = dwt_pkg::DWT_CTL_OPEN;
               end else begin
                  next_st.hw_lock = dwt_pkg::DWT_LOCKED;
               end
            end
            `DWT_HW_LOAD: begin
               if (st.hw_lock != dwt_pkg::DWT_LOCKED) begin
                  next_st.hw_load = pwdata;
                  next_st.hw_reload = 1'b1;
               end
               next_st.hw_lock = dwt_pkg::DWT_LOCKED;
               next_st.hw_kick_half = 1'b0;
            end
            `DWT_HW_CTL: begin
               if (st.hw_lock == dwt_pkg::DWT_CTL_OPEN) begin
                  next_st.hw_ctl = pwdata[1:0];
               end
               next_st.hw_lock = dwt_pkg::DWT_LOCKED;
               next_st.hw_kick_half = 1'b0;
            end
            `DWT_HW_KICK: begin
               if (st.hw_lock != dwt_pkg::DWT_LOCKED) begin
                  if (!st.hw_kick_half) begin
                     next_st.hw_kick_half = 1'b1;
                     next_st.hw_kick_val = pwdata[7:0];
                  end else begin
                     if (pwdata[7:0] == ~st.hw_kick_val) begin
                        next_st.hw_reload = 1'b1;
                     end
                     next_st.hw_lock = dwt_pkg::DWT_LOCKED;
                     next_st.hw_kick_half = 1'b0;
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '{
            pready: 1'b0,
            pslverr: 1'b0,
            prdata: 32'h00000000,
            sw_load: `DWT_SW_LOAD_RST,
            sw_ctl: `DWT_SW_CTL_RST,
            sw_locked: 1'b0,
            sw_div: `DWT_SW_DIV_RST,
            sw_div_cnt: 8'h00,
            sw_tick: 1'b0,
            sw_reload: 1'b0,
            hw_load: `DWT_HW_LOAD_RST,
            hw_ctl: `DWT_HW_CTL_RST,
            hw_lock: dwt_pkg::DWT_LOCKED,
            hw_kick_half: 1'b0,
            hw_kick_val: 8'h00,
            hw_reload: 1'b0,
            osc_s1: 1'b0,
            osc_s2: 1'b0,
            osc_s3: 1'b0,
            hw_tick: 1'b0
         };
      end else begin
         st <= next_st;
      end
   end

   // software watchdog counter
   dwt_core #(
      .COUNT_RST(`DWT_SW_LOAD_RST)
   ) u_sw (
      .pclk(pclk),
      .presetn(presetn),
      .tick(st.sw_tick),
      .enable(st.sw_ctl[`DWT_CTL_IRQ_BIT]),
      .rst_en(st.sw_ctl[`DWT_CTL_RST_BIT]),
      .reload(st.sw_reload),
      .load_val(st.sw_load),
      .count(sw_count),
      .irq(sw_pend),
      .rst_req(sw_wdg_reset)
   );

   // hardware watchdog counter, running from reset
   dwt_core #(
      .COUNT_RST(`DWT_HW_LOAD_RST)
   ) u_hw (
      .pclk(pclk),
      .presetn(presetn),
      .tick(st.hw_tick),
      .enable(st.hw_ctl[`DWT_CTL_IRQ_BIT]),
      .rst_en(st.hw_ctl[`DWT_CTL_RST_BIT]),
      .reload(st.hw_reload),
      .load_val(st.hw_load),
      .count(hw_count),
      .irq(hw_pend),
      .rst_req(hw_wdg_reset)
   );

   // outputs from state flops
   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign sw_irq = sw_pend;
   assign hw_irq = hw_pend;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_sw_lock_key: assert property (wr && paddr == `DWT_SW_KEY && pwdata != `DWT_UNLOCK_KEY
      |=> st.sw_locked)
      else $error("software key did not lock");
   a_sw_locked_ign: assert property (wr && paddr == `DWT_SW_LOAD && st.sw_locked
      |=> $stable(st.sw_load) && !st.sw_reload)
      else $error("locked software load changed");
   a_sw_kick_open: assert property (wr && paddr == `DWT_SW_KICK && !st.sw_locked
      |=> st.sw_reload && !st.sw_locked)
      else $error("software kick relocked or ignored");
   a_hw_ctl_guard: assert property (wr && paddr == `DWT_HW_CTL
      && st.hw_lock != dwt_pkg::DWT_CTL_OPEN |=> $stable(st.hw_ctl))
      else $error("hardware control written without double key");
   a_hw_kick_pair: assert property (wr && paddr == `DWT_HW_KICK && st.hw_kick_half
      && st.hw_lock != dwt_pkg::DWT_LOCKED && pwdata[7:0] == ~st.hw_kick_val
      |=> st.hw_reload ##1
      (!st.hw_ctl[`DWT_CTL_IRQ_BIT] || hw_count == $past(st.hw_load, 2)))
      else $error("hardware kick pair did not reload");
   a_hw_relock: assert property (wr && paddr == `DWT_HW_KICK && st.hw_kick_half
      |=> st.hw_lock == dwt_pkg::DWT_LOCKED)
      else $error("hardware did not relock after kick");
   a_apb_ready: assert property (acc && !st.pready |=> st.pready ##1 !st.pready)
      else $error("pready not a single cycle");

   c_sw_kick: cover property (wr && paddr == `DWT_SW_KICK && !st.sw_locked);
   c_hw_ctl_open: cover property (st.hw_lock == dwt_pkg::DWT_CTL_OPEN);
   c_hw_kick: cover property (st.hw_reload);

endmodule

`default_nettype wire

/* File: dv/dual_watchdog_timer_tb.sv */
// self-checking testbench of the dual watchdog block
`timescale 1ns/1ns
`default_nettype none
`include "dwt_defs.svh"
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("mismatch %s expected %h seen %h", nm, e, a); end end

module dual_watchdog_timer_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic osc = 1'b0;
   logic [3:0] osc_cnt = 4'h0;
   logic sw_irq;
   logic sw_wdg_reset;
   logic hw_irq;
   logic hw_wdg_reset;
   logic [31:0] rv;
   logic [31:0] v1;
   logic err;
   int error_cnt = 0;
   int checks = 0;
   wire logic [3:0] outs = {hw_wdg_reset, hw_irq, sw_wdg_reset, sw_irq};

   dwt_top dwt_top_inst (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .low_speed_osc_clock(osc),
      .sw_irq(sw_irq),
      .sw_wdg_reset(sw_wdg_reset),
      .hw_irq(hw_irq),
      .hw_wdg_reset(hw_wdg_reset)
   );

   // bus clock, 10 ns period
   always #5 pclk = ~pclk;

   // slow oscillator, one rising edge every 16 bus cycles
   always @(posedge pclk) begin
      osc_cnt <= osc_cnt + 4'h1;
      if (osc_cnt == 4'h7) begin
         osc_cnt <= 4'h0;
         osc <= ~osc;
      end
   end

   // verdict and end of run
   task automatic conclude;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // hang guard
   initial begin
      #200000;
      error_cnt++;
      conclude();
   end

   task automatic reset_dut;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   // one apb transfer: setup, access until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      `CHK("pready", 1'b1, pready)
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h00000000);
      `CHK(nm, e, rv)
      `CHK("mapped no err", 1'b0, err)
   endtask

   task automatic wait_hi(input int sel, input int lim);
      int n;
      n = 0;
      while (outs[sel] !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask

   task automatic hw_kick(input logic [7:0] b0, input logic [7:0] b1);
      wr(`DWT_HW_KEY, `DWT_UNLOCK_KEY);
      wr(`DWT_HW_KICK, {24'h000000, b0});
      wr(`DWT_HW_KICK, {24'h000000, b1});
   endtask

   // reset values, unmapped access, software lock
   task automatic sw_regs;
      reset_dut();
      rdchk(`DWT_SW_LOAD, 32'hFFFFFFFF, "sw load rst");
      rdchk(`DWT_SW_VALUE, 32'hFFFFFFFF, "sw value rst");
      rdchk(`DWT_SW_CTL, 32'h00000000, "sw ctl rst");
      rdchk(`DWT_SW_KEY, 32'h00000000, "sw unlocked rst");
      rdchk(`DWT_HW_LOAD, 32'h0000FFFF, "hw load rst");
      rdchk(`DWT_HW_CTL, 32'h00000003, "hw ctl rst");
      rdchk(`DWT_HW_KEY, 32'h00000001, "hw locked rst");
      apb(1'b0, 8'h7C, 32'h00000000);
      `CHK("unmapped err", 1'b1, err)
      wr(`DWT_SW_KEY, 32'h00000000);
      rdchk(`DWT_SW_KEY, 32'h00000001, "sw locked");
      wr(`DWT_SW_LOAD, 32'h00000010);
      rdchk(`DWT_SW_LOAD, 32'hFFFFFFFF, "sw load locked");
      wr(`DWT_SW_KEY, `DWT_UNLOCK_KEY);
      wr(`DWT_SW_DIV, 32'h00000000);
      wr(`DWT_SW_LOAD, 32'h00000020);
      rdchk(`DWT_SW_LOAD, 32'h00000020, "sw load rw");
   endtask

   // software counter: enables, underflow, kick, stop
   task automatic sw_run;
      wr(`DWT_SW_CTL, 32'h00000002);
      repeat (50) @(posedge pclk);
      rdchk(`DWT_SW_VALUE, 32'hFFFFFFFF, "sw idle rst only");
      `CHK("sw irq idle", 1'b0, sw_irq)
      wr(`DWT_SW_CTL, 32'h00000001);
      apb(1'b0, `DWT_SW_VALUE, 32'h00000000);
      `CHK("sw start reload", 1'b1, (rv <= 32'h20 && rv >= 32'h18))
      wait_hi(0, 200);
      `CHK("sw irq", 1'b1, sw_irq)
      rdchk(`DWT_SW_RIS, 32'h00000001, "sw ris");
      repeat (100) @(posedge pclk);
      `CHK("sw no rst irq only", 1'b0, sw_wdg_reset)
      wr(`DWT_SW_KEY, `DWT_UNLOCK_KEY);
      wr(`DWT_SW_KICK, 32'h12345678);
      rdchk(`DWT_SW_RIS, 32'h00000000, "sw kick clears");
      apb(1'b0, `DWT_SW_VALUE, 32'h00000000);
      `CHK("sw kick reload", 1'b1, (rv <= 32'h20 && rv >= 32'h18))
      rdchk(`DWT_SW_KEY, 32'h00000000, "sw open after kick");
      wr(`DWT_SW_CTL, 32'h00000003);
      wait_hi(1, 200);
      `CHK("sw rst", 1'b1, sw_wdg_reset)
      wr(`DWT_SW_CTL, 32'h00000000);
      apb(1'b0, `DWT_SW_VALUE, 32'h00000000);
      v1 = rv;
      repeat (30) @(posedge pclk);
      rdchk(`DWT_SW_VALUE, v1, "sw stopped");
      // divide by four: 44 cycles between two value captures give 11 ticks
      wr(`DWT_SW_DIV, 32'h00000003);
      rdchk(`DWT_SW_DIV, 32'h00000003, "sw div rw");
      wr(`DWT_SW_CTL, 32'h00000001);
      apb(1'b0, `DWT_SW_VALUE, 32'h00000000);
      v1 = rv;
      repeat (40) @(posedge pclk);
      apb(1'b0, `DWT_SW_VALUE, 32'h00000000);
      `CHK("sw div ticks", v1 - 32'h0000000B, rv)
   endtask

   // hardware lock, load write, free run from reset
   task automatic hw_load_run;
      reset_dut();
      wr(`DWT_HW_LOAD, 32'h00000008);
      rdchk(`DWT_HW_LOAD, 32'h0000FFFF, "hw load locked");
      wr(`DWT_HW_KEY, `DWT_UNLOCK_KEY);
      rdchk(`DWT_HW_KEY, 32'h00000000, "hw open");
      wr(`DWT_HW_LOAD, 32'h00000040);
      rdchk(`DWT_HW_LOAD, 32'h00000040, "hw load rw");
      rdchk(`DWT_HW_KEY, 32'h00000001, "hw relock load");
      apb(1'b0, `DWT_HW_VALUE, 32'h00000000);
      `CHK("hw load reload", 1'b1, (rv <= 32'h40 && rv >= 32'h3E))
      wait_hi(2, 1500);
      `CHK("hw irq", 1'b1, hw_irq)
      rdchk(`DWT_HW_RIS, 32'h00000001, "hw ris");
      `CHK("hw no rst yet", 1'b0, hw_wdg_reset)
      wait_hi(3, 1500);
      `CHK("hw rst", 1'b1, hw_wdg_reset)
   endtask

   // double unlock of control, stop, restart, kick pairs
   task automatic hw_ctl_kick;
      reset_dut();
      wr(`DWT_HW_KEY, `DWT_UNLOCK_KEY);
      wr(`DWT_HW_CTL, 32'h00000000);
      rdchk(`DWT_HW_CTL, 32'h00000003, "hw ctl single key");
      wr(`DWT_HW_KEY, `DWT_UNLOCK_KEY);
      wr(`DWT_HW_KEY, 32'h12345678);
      wr(`DWT_HW_KEY, `DWT_CTL_KEY);
      wr(`DWT_HW_CTL, 32'h00000000);
      rdchk(`DWT_HW_CTL, 32'h00000003, "hw ctl bad seq");
      wr(`DWT_HW_KEY, `DWT_UNLOCK_KEY);
      wr(`DWT_HW_KEY, `DWT_CTL_KEY);
      wr(`DWT_HW_CTL, 32'h00000000);
      rdchk(`DWT_HW_CTL, 32'h00000000, "hw ctl written");
      rdchk(`DWT_HW_KEY, 32'h00000001, "hw relock ctl");
      apb(1'b0, `DWT_HW_VALUE, 32'h00000000);
      v1 = rv;
      repeat (40) @(posedge pclk);
      rdchk(`DWT_HW_VALUE, v1, "hw stopped");
      wr(`DWT_HW_KEY, `DWT_UNLOCK_KEY);
      wr(`DWT_HW_LOAD, 32'h00000030);
      wr(`DWT_HW_KEY, `DWT_UNLOCK_KEY);
      wr(`DWT_HW_KEY, `DWT_CTL_KEY);
      wr(`DWT_HW_CTL, 32'h00000001);
      apb(1'b0, `DWT_HW_VALUE, 32'h00000000);
      `CHK("hw restart reload", 1'b1, (rv <= 32'h30 && rv >= 32'h2E))
      repeat (100) @(posedge pclk);
      apb(1'b0, `DWT_HW_VALUE, 32'h00000000);
      v1 = rv;
      hw_kick(8'h5A, 8'h00);
      apb(1'b0, `DWT_HW_VALUE, 32'h00000000);
      `CHK("hw bad kick", 1'b1, (rv <= v1))
      hw_kick(8'h5A, 8'hA5);
      apb(1'b0, `DWT_HW_VALUE, 32'h00000000);
      `CHK("hw kick reload", 1'b1, (rv <= 32'h30 && rv >= 32'h2E))
      rdchk(`DWT_HW_KEY, 32'h00000001, "hw relock kick");
      wait_hi(2, 1200);
      `CHK("hw irq only", 1'b1, hw_irq)
      hw_kick(8'h0F, 8'hF0);
      rdchk(`DWT_HW_RIS, 32'h00000000, "hw kick clears");
      `CHK("hw no rst", 1'b0, hw_wdg_reset)
   endtask

   // main sequence
   initial begin
      sw_regs();
      sw_run();
      hw_load_run();
      hw_ctl_kick();
      reset_dut();
      rdchk(`DWT_SW_CTL, 32'h00000000, "sw ctl after rst");
      `CHK("sw rst cleared", 1'b0, sw_wdg_reset)
      conclude();
   end
endmodule

`default_nettype wire
